// >>> verilog/per_router.sv
// Peripheral event router: generator muxes, channel subchannels, listener and pin muxes.
`timescale 1ns/100ps
`default_nettype none
`include "per_defs.svh"

module per_router #(
  parameter int                     NUM_CHANNELS = `PER_NUM_CHANNELS,
  parameter int                     NUM_GENS     = `PER_NUM_GENS,
  parameter int                     NUM_USERS    = `PER_NUM_USERS,
  parameter int                     NUM_PORTS    = `PER_NUM_PORTS,
  // Bit g set marks generator g as asynchronous to the peripheral clock
  parameter logic [NUM_GENS-1:0]    GEN_IS_ASYNC = '0
) (
  input  wire logic                              CORE_CLK_I,
  input  wire logic                              RST_I,
  input  wire logic [NUM_GENS-1:0]               GEN_EVENT_I,
  input  wire logic [NUM_CHANNELS-1:0]           SW_EVENT_I,
  input  wire logic [NUM_CHANNELS*`PER_SEL_W-1:0] GENERATOR_SELECT_I,
  input  wire logic [NUM_USERS*`PER_SEL_W-1:0]   LISTENER_SELECT_I,
  input  wire logic [NUM_PORTS*`PER_SEL_W-1:0]   EVENT_PIN_SELECT_I,
  output logic      [NUM_CHANNELS-1:0]           CHANNEL_ASYNC_O,
  output logic      [NUM_CHANNELS-1:0]           CHANNEL_SYNC_O,
  output logic      [NUM_USERS-1:0]              USER_ASYNC_O,
  output logic      [NUM_USERS-1:0]              USER_SYNC_O,
  output logic      [NUM_PORTS-1:0]              EVENT_PIN_OUTPUT_O,
  output logic      [NUM_PORTS-1:0]              EVENT_PIN_OE_O
);

  // Select values are 8 bits wide, so no more than 255 items can be addressed
  generate
    if (NUM_CHANNELS < 1 || NUM_CHANNELS > `PER_MAX_ITEMS) begin : g_bad_channels
      $error("per_router: NUM_CHANNELS out of range");
    end
    if (NUM_GENS < 1 || NUM_GENS > `PER_MAX_ITEMS) begin : g_bad_gens
      $error("per_router: NUM_GENS out of range");
    end
    if (NUM_USERS < 1 || NUM_PORTS < 1) begin : g_bad_users
      $error("per_router: NUM_USERS and NUM_PORTS must be at least one");
    end
  endgenerate

  // Select value 0 is "none"; value k picks generator k-1; larger values pick nothing
  function automatic logic gen_pick(input per_pkg::per_sel_t sel,
                                    input logic [NUM_GENS-1:0] ev);
    logic hit;
    hit = `PER_EVENT_IDLE;
    for (int g = 0; g < NUM_GENS; g++) begin
      if (sel == per_pkg::per_sel_t'(g + 1)) begin
        hit = ev[g];
      end
    end
    return hit;
  endfunction : gen_pick

  // Select value 0 is "none"; value k picks channel k-1; unknown channels stay silent
  function automatic logic chan_pick(input per_pkg::per_sel_t sel,
                                     input logic [NUM_CHANNELS-1:0] ch);
    logic hit;
    hit = `PER_EVENT_IDLE;
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      if (sel == per_pkg::per_sel_t'(c + 1)) begin
        hit = ch[c];
      end
    end
    return hit;
  endfunction : chan_pick

  function automatic logic chan_valid(input per_pkg::per_sel_t sel);
    return (sel >= `PER_SEL_FIRST) && (sel <= per_pkg::per_sel_t'(NUM_CHANNELS));
  endfunction : chan_valid

  // Generator events as seen on the peripheral clock
  logic [NUM_GENS-1:0] gen_clocked;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_GENS; gi++) begin : g_gen
      if (GEN_IS_ASYNC[gi]) begin : g_async
        per_sync u_sync (
          .clk_i   (CORE_CLK_I),
          .rst_i   (RST_I),
          .async_i (GEN_EVENT_I[gi]),
          .sync_o  (gen_clocked[gi])
        );
      end else begin : g_sync
        // Already on the peripheral clock: no extra delay, pulse width kept
        assign gen_clocked[gi] = GEN_EVENT_I[gi];
      end
    end
  endgenerate

  // Asynchronous subchannel: pure gates, so it still carries events when the
  // peripheral clock is stopped in sleep; it and USER_ASYNC_O are the only outputs not taken from a flop
  logic [NUM_CHANNELS-1:0] chan_async;

  always_comb begin
    chan_async = '0;
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      chan_async[c] = gen_pick(GENERATOR_SELECT_I[c*`PER_SEL_W +: `PER_SEL_W],
                               GEN_EVENT_I)
                      | SW_EVENT_I[c];
    end
  end

  assign CHANNEL_ASYNC_O = chan_async;

  // Synchronous subchannel and everything that listens to it share one flop stage,
  // so a one-cycle generator pulse stays one cycle wide at every sync listener
  logic [NUM_CHANNELS-1:0] chan_sync;
  logic [NUM_CHANNELS-1:0] next_chan_sync;
  logic [NUM_USERS-1:0]    user_sync;
  logic [NUM_USERS-1:0]    next_user_sync;
  logic [NUM_PORTS-1:0]    pin_out;
  logic [NUM_PORTS-1:0]    next_pin_out;
  logic [NUM_PORTS-1:0]    pin_oe;
  logic [NUM_PORTS-1:0]    next_pin_oe;

  always_comb begin
    next_chan_sync = '0;
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      next_chan_sync[c] = gen_pick(GENERATOR_SELECT_I[c*`PER_SEL_W +: `PER_SEL_W],
                                   gen_clocked)
                          | SW_EVENT_I[c];
    end
  end

  always_comb begin
    next_user_sync = '0;
    for (int u = 0; u < NUM_USERS; u++) begin
      next_user_sync[u] = chan_pick(LISTENER_SELECT_I[u*`PER_SEL_W +: `PER_SEL_W],
                                    next_chan_sync);
    end
  end

  always_comb begin
    next_pin_out = '0;
    next_pin_oe  = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      next_pin_out[p] = chan_pick(EVENT_PIN_SELECT_I[p*`PER_SEL_W +: `PER_SEL_W],
                                  next_chan_sync);
      next_pin_oe[p]  = chan_valid(EVENT_PIN_SELECT_I[p*`PER_SEL_W +: `PER_SEL_W]);
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      chan_sync <= '0;
      user_sync <= '0;
      pin_out   <= '0;
      pin_oe    <= '0;
    end else begin
      chan_sync <= next_chan_sync;
      user_sync <= next_user_sync;
      pin_out   <= next_pin_out;
      pin_oe    <= next_pin_oe;
    end
  end

  assign CHANNEL_SYNC_O     = chan_sync;
  assign USER_SYNC_O        = user_sync;
  assign EVENT_PIN_OUTPUT_O = pin_out;
  assign EVENT_PIN_OE_O     = pin_oe;

  // Async listeners see no flop at all; a generator feeding a sync listener from an
  // async source must hold its level for a full clock so the synchroniser catches it
  always_comb begin
    USER_ASYNC_O = '0;
    for (int u = 0; u < NUM_USERS; u++) begin
      USER_ASYNC_O[u] = chan_pick(LISTENER_SELECT_I[u*`PER_SEL_W +: `PER_SEL_W],
                                  chan_async);
    end
  end

endmodule : per_router

`default_nettype wire

// >>> inc/per_defs.svh
// Constants of the peripheral event router: widths, select codes, reset values, timing.
// Overview of operation
// - Up to six event channels run in parallel, each carrying its own event.
// - One selected generator drives each channel; any number of users may listen.
// - A per-channel generator select steers the input multiplexer of that channel.
// - Each user has its own listener select choosing which channel it hears.
// - Each channel has async and sync subchannels; users take the matching one.
// - Asynchronous sources pass a peripheral-clock synchroniser before the sync subchannel.
// - The synchroniser delays an asynchronous event by two to three clock cycles.
// - Channel events can drive one digital event output pin per I/O port.
// - Routing keeps working in active, idle and standby sleep modes.
// - Software may inject an event onto a channel besides hardware generators.
// - After reset no channel is connected to any generator.
// - A synchronous pulse from the peripheral clock lasts exactly one cycle.
`ifndef PER_DEFS_SVH
`define PER_DEFS_SVH

`define PER_SEL_W         8
`define PER_SEL_NONE      8'h00
`define PER_SEL_FIRST     8'h01
`define PER_MAX_ITEMS     255
`define PER_NUM_CHANNELS  6
`define PER_NUM_GENS      16
`define PER_NUM_USERS     8
`define PER_NUM_PORTS     2
`define PER_SYNC_STAGES   2
`define PER_EVENT_IDLE    1'b0

`endif

// >>> inc/per_pkg.sv
// Types shared by the peripheral event router files.
`include "per_defs.svh"

package per_pkg;

  typedef logic [`PER_SEL_W-1:0] per_sel_t;

  typedef logic [`PER_SYNC_STAGES-1:0] per_sync_chain_t;

endpackage : per_pkg

// >>> verilog/per_sync.sv
// Two-stage synchroniser bringing one asynchronous event onto the peripheral clock.
`timescale 1ns/100ps
`default_nettype none
`include "per_defs.svh"

module per_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);

  per_pkg::per_sync_chain_t chain;
  per_pkg::per_sync_chain_t next_chain;

  // Stage 0 is read only by stage 1, so metastability never reaches logic
  always_comb begin
    next_chain = {chain[`PER_SYNC_STAGES-2:0], async_i};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain <= {`PER_SYNC_STAGES{`PER_EVENT_IDLE}};
    end else begin
      chain <= next_chain;
    end
  end

  assign sync_o = chain[`PER_SYNC_STAGES-1];

endmodule : per_sync

`default_nettype wire

// >>> dv/per_gen_model.sv
// Generator-side model driving sync and async event lines.
`timescale 1ns/100ps
`default_nettype none
module per_gen_model #(
  parameter int NUM_GENS = 16,
  parameter logic [NUM_GENS-1:0] GEN_IS_ASYNC = '0
) (
  input wire logic clk_i,
  input wire logic en_i,
  output logic [NUM_GENS-1:0] gen_o
);
  integer seed = 32'hd1f03092;
  logic flip = 1'b0;
  initial gen_o = '0;
  // Sync lines move once per cycle, so a pulse spans exactly one clock
  always @(negedge clk_i) begin
    gen_o = (gen_o & GEN_IS_ASYNC) | (NUM_GENS'($random(seed)) & ~GEN_IS_ASYNC & {NUM_GENS{en_i}});
  end
  // Async lines move off-edge and every second cycle, so each level outlives one clock
  always @(posedge clk_i) begin
    flip = ~flip;
    #13;
    if (flip) gen_o = (gen_o & ~GEN_IS_ASYNC) | (NUM_GENS'($random(seed)) & GEN_IS_ASYNC);
  end
endmodule : per_gen_model
`default_nettype wire

// >>> dv/per_router_props.sv
// Port assertions of the router for channel 0, user 0 and port 0.
`timescale 1ns/100ps
`default_nettype none
module per_router_props #(
  parameter int NUM_CHANNELS = 6,
  parameter int NUM_GENS = 16,
  parameter int NUM_USERS = 8,
  parameter int NUM_PORTS = 2,
  parameter logic [NUM_GENS-1:0] GEN_IS_ASYNC = '0
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [NUM_GENS-1:0] GEN_EVENT_I,
  input wire logic [NUM_CHANNELS-1:0] SW_EVENT_I,
  input wire logic [NUM_CHANNELS*8-1:0] GENERATOR_SELECT_I,
  input wire logic [NUM_USERS*8-1:0] LISTENER_SELECT_I,
  input wire logic [NUM_PORTS*8-1:0] EVENT_PIN_SELECT_I,
  input wire logic [NUM_CHANNELS-1:0] CHANNEL_ASYNC_O,
  input wire logic [NUM_CHANNELS-1:0] CHANNEL_SYNC_O,
  input wire logic [NUM_USERS-1:0] USER_ASYNC_O,
  input wire logic [NUM_USERS-1:0] USER_SYNC_O,
  input wire logic [NUM_PORTS-1:0] EVENT_PIN_OUTPUT_O,
  input wire logic [NUM_PORTS-1:0] EVENT_PIN_OE_O
);
  logic [7:0] gs, ls, ps;
  logic gv, ga, gsw, lv, pv;
  always_comb begin
    gs = GENERATOR_SELECT_I[7:0];
    ls = LISTENER_SELECT_I[7:0];
    ps = EVENT_PIN_SELECT_I[7:0];
    gv = (gs != 8'h00 && gs <= NUM_GENS) ? GEN_EVENT_I[gs-8'h01] : 1'b0;
    ga = (gs != 8'h00 && gs <= NUM_GENS) ? GEN_IS_ASYNC[gs-8'h01] : 1'b0;
    gsw = gv | SW_EVENT_I[0];
    lv = ls != 8'h00 && ls <= NUM_CHANNELS;
    pv = ps != 8'h00 && ps <= NUM_CHANNELS;
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_pulse;
    !ga && !SW_EVENT_I[0] && gv ##1 !ga && !SW_EVENT_I[0] && !gv;
  endsequence
  property p_rst; $fell(RST_I) |-> {CHANNEL_SYNC_O, USER_SYNC_O, EVENT_PIN_OE_O} == '0; endproperty
  property p_async; !SW_EVENT_I[0] |-> CHANNEL_ASYNC_O[0] == gv; endproperty
  property p_sync; !ga |=> CHANNEL_SYNC_O[0] == $past(gsw); endproperty
  property p_adly; (ga && $stable(gs) && !SW_EVENT_I[0]) [*4] |-> CHANNEL_SYNC_O[0] == $past(gv, 3); endproperty
  property p_pulse; s_pulse |-> CHANNEL_SYNC_O[0] ##1 !CHANNEL_SYNC_O[0]; endproperty
  property p_usync; $stable(ls) |-> USER_SYNC_O[0] == (lv && CHANNEL_SYNC_O[ls-8'h01]); endproperty
  property p_poe; !$past(RST_I) |-> EVENT_PIN_OE_O[0] == $past(pv); endproperty
  property p_pout; $stable(ps) |-> EVENT_PIN_OUTPUT_O[0] == (pv && CHANNEL_SYNC_O[ps-8'h01]); endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_async: assert property (p_async) else $error("async subchannel wrong");
  a_sync: assert property (p_sync) else $error("sync subchannel wrong");
  a_adly: assert property (p_adly) else $error("synchroniser delay wrong");
  a_pulse: assert property (p_pulse) else $error("pulse length wrong");
  a_usync: assert property (p_usync) else $error("listener mux wrong");
  a_poe: assert property (p_poe) else $error("pin enable wrong");
  a_pout: assert property (p_pout) else $error("pin level wrong");
endmodule : per_router_props
`default_nettype wire

// >>> dv/tb_per_router.sv
// Random bench comparing the event router with a cycle model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_per_router;
  localparam logic [15:0] ASY = 16'hff00;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0;
  logic [15:0] gen;
  logic [5:0] sw = 6'h00, cha, chs, g1, g2, es, ea;
  logic [47:0] gsel = 48'h0;
  logic [63:0] lsel = 64'h0;
  logic [15:0] psel = 16'h0;
  logic [7:0] ua, us, eu, eua;
  logic [1:0] po, poe, ep, eo;
  int fail_count = 0;
  int n_compared = 0;
  integer seed = 32'hd1f03092;
  always #25 clk = ~clk;
  per_gen_model #(.NUM_GENS(16), .GEN_IS_ASYNC(ASY)) u_gen (.clk_i(clk), .en_i(en), .gen_o(gen));
  per_router #(.GEN_IS_ASYNC(ASY)) DUT (.CORE_CLK_I(clk), .RST_I(rst), .GEN_EVENT_I(gen),
    .SW_EVENT_I(sw), .GENERATOR_SELECT_I(gsel), .LISTENER_SELECT_I(lsel),
    .EVENT_PIN_SELECT_I(psel), .CHANNEL_ASYNC_O(cha), .CHANNEL_SYNC_O(chs), .USER_ASYNC_O(ua),
    .USER_SYNC_O(us), .EVENT_PIN_OUTPUT_O(po), .EVENT_PIN_OE_O(poe));
  function automatic logic sel(input logic [7:0] s, input int n, input logic [15:0] v);
    return (s != 8'h00 && s <= n) ? v[s-8'h01] : 1'b0;
  endfunction : sel
  // Async sources go through two stages before the output register
  always @(posedge clk) begin
    for (int c = 0; c < 6; c++) begin
      g1[c] <= !rst && sel(gsel[c*8+:8], 16, gen);
      g2[c] <= !rst && g1[c];
      es[c] <= !rst && ((sel(gsel[c*8+:8], 16, ASY) ? g2[c] : g1[c] ^ g1[c] | sel(gsel[c*8+:8], 16, gen)) | sw[c]);
    end
  end
  task automatic check();
    for (int c = 0; c < 6; c++) ea[c] = sel(gsel[c*8+:8], 16, gen);
    for (int u = 0; u < 8; u++) begin
      eu[u] = sel(lsel[u*8+:8], 6, 16'(es));
      eua[u] = sel(lsel[u*8+:8], 6, 16'(ea | sw));
    end
    for (int p = 0; p < 2; p++) begin
      ep[p] = sel(psel[p*8+:8], 6, 16'(es));
      eo[p] = sel(psel[p*8+:8], 6, 16'hffff);
    end
    if (sw == 6'h00) `CHK(cha, ea)
    `CHK(chs, es)
    `CHK(us, eu)
    `CHK(ua, eua)
    `CHK({po, poe}, {ep, eo})
  endtask : check
  task automatic wrap_up();
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    en = 1'b1;
    for (int ph = 0; ph < 40; ph++) begin
      rst = (ph == 20);
      for (int c = 0; c < 6; c++) gsel[c*8+:8] = (ph < 2) ? 8'h00 : 8'($unsigned($random(seed)) % 19);
      for (int u = 0; u < 8; u++) lsel[u*8+:8] = 8'($unsigned($random(seed)) % 9);
      psel = {8'($unsigned($random(seed)) % 9), 8'($unsigned($random(seed)) % 9)};
      for (int k = 0; k < 40; k++) begin
        @(negedge clk);
        rst = 1'b0;
        sw = k[0] ? 6'($random(seed)) : 6'h00;
        // Let the generator model's falling-edge update settle before sampling
        #1;
        if (k > 3) check();
      end
    end
    wrap_up();
  end
  initial begin
    #(3000 * 50);
    fail_count++;
    wrap_up();
  end
endmodule : tb_per_router
bind per_router per_router_props #(.NUM_CHANNELS(NUM_CHANNELS), .NUM_GENS(NUM_GENS),
  .NUM_USERS(NUM_USERS), .NUM_PORTS(NUM_PORTS), .GEN_IS_ASYNC(GEN_IS_ASYNC)) u_props (
  .CORE_CLK_I, .RST_I, .GEN_EVENT_I, .SW_EVENT_I, .GENERATOR_SELECT_I, .LISTENER_SELECT_I,
  .EVENT_PIN_SELECT_I, .CHANNEL_ASYNC_O, .CHANNEL_SYNC_O, .USER_ASYNC_O, .USER_SYNC_O,
  .EVENT_PIN_OUTPUT_O, .EVENT_PIN_OE_O);
`default_nettype wire
